// ===== logic/test_mode_tristate_entry.sv
// Test-mode entry logic that forces all user pins to high impedance.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1: Mode pin high selects test mode; low returns to normal operation.
// R2: In test mode one data bit is captured per rising shift clock edge, seven total.
// R3: The seven-bit pattern 0001011 is the three-state command.
// R4: After the seventh bit matches, all user pins float until mode goes low.
// R5: Isolation applies to input, output and three-stateable pins alike.
// R6: The user design leaves data and shift clock pins unused or as inputs.
// R7: The tester keeps the shift clock below 1.0 MHz; the bench's tester_model runs it at 5 MHz.
// R8: Leftmost bit first on rising edges; a mismatch leaves pins normal.
module test_mode_tristate_entry (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic mode_pin_in,
  input wire logic serial_test_data_in,
  input wire logic debug_shift_clock_in,
  input wire logic [tristate_entry_pkg::USER_PINS-1:0] user_out_in,
  input wire logic [tristate_entry_pkg::USER_PINS-1:0] user_oe_in,
  input wire logic [tristate_entry_pkg::USER_PINS-1:0] user_pin_in,
  output logic [tristate_entry_pkg::USER_PINS-1:0] pin_out,
  output logic [tristate_entry_pkg::USER_PINS-1:0] pin_oe_out,
  output logic [tristate_entry_pkg::USER_PINS-1:0] user_in_out,
  output logic isolated_out
);
  tristate_pin_if pins ();

  test_pin_sync u_sync (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .mode_pin_in(mode_pin_in),
    .serial_test_data_in(serial_test_data_in),
    .debug_shift_clock_in(debug_shift_clock_in),
    .pins(pins)
  );

  tristate_entry_pkg::entry_state_e state_q, state_d;
  logic [6:0] shift_q, shift_d;
  logic [2:0] count_q, count_d;
  logic iso_q, iso_d;
  logic [tristate_entry_pkg::USER_PINS-1:0] out_q, out_d;
  logic [tristate_entry_pkg::USER_PINS-1:0] in_q, in_d;
  logic [tristate_entry_pkg::USER_PINS-1:0] oe_q;
  wire logic [tristate_entry_pkg::USER_PINS-1:0] oe_d;

  // Named decodes of the synchronised pins and of the entry state.
  logic mode_seen;
  logic bit_strobe;
  logic bit_value;
  logic in_shift;
  logic [6:0] shifted;
  logic last_bit;
  logic locked;
  logic match;
  logic take_bit;
  logic enter_iso;
  logic hit_mismatch;
  logic clear_pattern;
  logic drop_mode;
  logic iso_next;

  // True only in the state in which the user pins are released.
  function automatic logic in_isolation(input tristate_entry_pkg::entry_state_e st);
    return st == tristate_entry_pkg::ST_ISOLATE;
  endfunction

  // New bits enter at the bottom, so the first bit ends in the top position.
  function automatic logic [6:0] shift_in(input logic [6:0] word, input logic bit_in);
    return {word[5:0], bit_in};
  endfunction

  function automatic logic is_last(input logic [2:0] count);
    return count == 3'(tristate_entry_pkg::PATTERN_LEN - 1);
  endfunction

  // A full count means that seven bits went by without a match.
  function automatic logic is_locked(input logic [2:0] count);
    return count == tristate_entry_pkg::COUNT_LAST;
  endfunction

  function automatic logic is_command(input logic [6:0] word);
    return word == tristate_entry_pkg::THREE_STATE_CMD;
  endfunction

  function automatic logic [2:0] count_step(input logic [2:0] count);
    return count + 3'h1;
  endfunction

  assign mode_seen = pins.mode; // R1
  assign bit_strobe = pins.clk_rise; // R8
  assign bit_value = pins.data;
  assign in_shift = (state_q == tristate_entry_pkg::ST_SHIFT);
  assign shifted = shift_in(shift_q, bit_value); // R8
  assign last_bit = is_last(count_q); // R2
  assign locked = is_locked(count_q); // R8
  assign match = is_command(shifted); // R3
  assign take_bit = in_shift && mode_seen && bit_strobe && !locked; // R2
  assign enter_iso = take_bit && last_bit && match; // R4
  assign hit_mismatch = take_bit && last_bit && !match; // R8
  assign clear_pattern = !in_shift;
  // Mode low always wins, in the middle of a pattern as well as while isolated.
  assign drop_mode = !mode_seen; // R1 R4
  assign iso_next = in_isolation(state_d); // R4

  always_comb begin
    state_d = state_q;
    case (state_q)
      tristate_entry_pkg::ST_NORMAL: begin
        if (mode_seen) begin
          state_d = tristate_entry_pkg::ST_SHIFT; // R1
        end
      end
      tristate_entry_pkg::ST_SHIFT: begin
        // A pattern that misses stays here, locked, until mode falls.
        if (drop_mode) begin
          state_d = tristate_entry_pkg::ST_NORMAL; // R1
        end else if (enter_iso) begin
          state_d = tristate_entry_pkg::ST_ISOLATE; // R4
        end
      end
      tristate_entry_pkg::ST_ISOLATE: begin
        if (drop_mode) begin
          state_d = tristate_entry_pkg::ST_NORMAL; // R4
        end
      end
      default: begin
        state_d = tristate_entry_pkg::ST_NORMAL;
      end
    endcase
  end

  // Outside the shift state the pattern and the count start again from empty.
  always_comb begin
    shift_d = shift_q;
    count_d = count_q;
    if (clear_pattern) begin
      shift_d = tristate_entry_pkg::SHIFT_RESET;
      count_d = tristate_entry_pkg::COUNT_RESET;
    end else if (hit_mismatch) begin
      // A wrong pattern is ignored until mode is dropped and raised again.
      shift_d = shifted;
      count_d = tristate_entry_pkg::COUNT_LAST; // R8
    end else if (take_bit) begin
      shift_d = shifted; // R2
      count_d = count_step(count_q); // R2
    end
  end

  // Each register has a process of its own so that every process stays short.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_q <= tristate_entry_pkg::ST_NORMAL;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      shift_q <= tristate_entry_pkg::SHIFT_RESET;
    end else begin
      shift_q <= shift_d;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      count_q <= tristate_entry_pkg::COUNT_RESET;
    end else begin
      count_q <= count_d;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      iso_q <= 1'b0;
    end else begin
      iso_q <= iso_d;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      out_q <= '0;
    end else begin
      out_q <= out_d;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      oe_q <= '0;
    end else begin
      oe_q <= oe_d;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      in_q <= '0;
    end else begin
      in_q <= in_d;
    end
  end

  // The pad and data paths add one register stage and nothing else.
  assign iso_d = iso_next; // R4
  assign out_d = user_out_in;
  assign in_d = user_pin_in;

  // Every enable drops, whatever the pin's normal direction.
  for (genvar g = 0; g < tristate_entry_pkg::USER_PINS; g++) begin : g_pin
    assign oe_d[g] = user_oe_in[g] & ~iso_next; // R4 R5
  end

  // Data outputs come straight from flip-flops, with no logic behind them.
  assign pin_out = out_q;
  assign pin_oe_out = oe_q; // R5
  assign user_in_out = in_q;
  assign isolated_out = iso_q; // R4
endmodule
`default_nettype wire

// ===== logic/tristate_entry_pkg.sv
// Constants shared by the test-mode three-state entry logic.
`default_nettype none
package tristate_entry_pkg;
  localparam int unsigned PATTERN_LEN = 7;
  localparam logic [6:0] THREE_STATE_CMD = 7'h0b;
  localparam logic [6:0] SHIFT_RESET = 7'h00;
  localparam logic [2:0] COUNT_RESET = 3'h0;
  localparam logic [2:0] COUNT_LAST = 3'h7;
  localparam int unsigned USER_PINS = 16;
  localparam real CLK_PERIOD_NS = 25.0;
  localparam real MAX_SHIFT_FREQ_MHZ = 1.0;
  // Shortest shift-clock period, in system clocks, for the documented top frequency.
  localparam int unsigned MIN_SHIFT_PERIOD_CYC = int'((1000.0 / MAX_SHIFT_FREQ_MHZ) / CLK_PERIOD_NS);
  typedef enum logic [2:0] {
    ST_NORMAL = 3'b001,
    ST_SHIFT = 3'b010,
    ST_ISOLATE = 3'b100
  } entry_state_e;
endpackage
`default_nettype wire

// ===== logic/tristate_pin_if.sv
// Signals passed from the pin sync stage to the entry logic.
`timescale 1ns/1ps
`default_nettype none
interface tristate_pin_if;
  logic mode;
  logic data;
  logic clk_rise;
  modport sync_side (output mode, output data, output clk_rise);
  modport core_side (input mode, input data, input clk_rise);
endinterface
`default_nettype wire

// ===== logic/test_pin_sync.sv
// Two-stage synchronisers for the test pins and shift-clock edge detect.
`timescale 1ns/1ps
`default_nettype none
module test_pin_sync (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic mode_pin_in,
  input wire logic serial_test_data_in,
  input wire logic debug_shift_clock_in,
  tristate_pin_if.sync_side pins
);
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic clk_prev_q;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      meta_q <= 3'h0;
      sync_q <= 3'h0;
      clk_prev_q <= 1'b0;
    end else begin
      meta_q <= {debug_shift_clock_in, serial_test_data_in, mode_pin_in};
      sync_q <= meta_q;
      clk_prev_q <= sync_q[2];
    end
  end

  assign pins.mode = sync_q[0];
  assign pins.data = sync_q[1];
  // Rising edge of the shift clock; data is sampled from the same stage.
  assign pins.clk_rise = sync_q[2] & ~clk_prev_q; // R8
endmodule
`default_nettype wire

// ===== sim/tristate_entry_assertions.sv
// Port assertions for the test-mode three-state entry logic.
`timescale 1ns/1ps
`default_nettype none
module tristate_entry_assertions (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic mode_pin_in,
  input wire logic debug_shift_clock_in,
  input wire logic [15:0] user_out_in,
  input wire logic [15:0] user_oe_in,
  input wire logic [15:0] user_pin_in,
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe_out,
  input wire logic [15:0] user_in_out,
  input wire logic isolated_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  a_iso_floats: assert property (isolated_out |-> pin_oe_out == 16'h0) else $error("enable on while isolated");
  a_oe_follows: assert property (!isolated_out && !$past(isolated_out) && !$past(rst_in) |->
    pin_oe_out == $past(user_oe_in)) else $error("enable not passed through");
  a_out_copy: assert property ($past(!rst_in) |-> pin_out == $past(user_out_in)) else $error("pin data wrong");
  a_in_copy: assert property ($past(!rst_in) |-> user_in_out == $past(user_pin_in)) else $error("pad input wrong");
  a_needs_mode: assert property ($rose(isolated_out) |-> $past(mode_pin_in, 3)) else $error("isolated without mode");
  a_after_edge: assert property ($rose(isolated_out) |->
    $past(debug_shift_clock_in, 3) && !$past(debug_shift_clock_in, 4)) else $error("no shift edge");
  a_iso_holds: assert property (mode_pin_in [*5] ##0 isolated_out |=> isolated_out) else $error("isolation lost");
  a_mode_exit: assert property (!mode_pin_in [*6] |-> !isolated_out) else $error("isolation kept after mode low");
endmodule
`default_nettype wire

// ===== sim/tester_model.sv
// Board tester that drives the mode, serial data and shift clock pins.
`timescale 1ns/1ps
`default_nettype none
module tester_model (
  output var logic mode_out,
  output var logic sdata_out,
  output var logic sclk_out
);
  // Data and clock are only ever driven into the device, never read back.
  initial begin
    mode_out = 1'b0;
    sdata_out = 1'b0;
    sclk_out = 1'b0;
  end
  task automatic set_mode(input logic m);
    mode_out = m;
    #511;
  endtask
  // Sends the n leftmost bits, each set up half a period before its rising edge.
  // Each level stands 100 ns, four system clocks; a board tester keeps the clock under 1.0 MHz, this model runs it at 5 MHz.
  task automatic shift(input logic [6:0] pat, input int n);
    for (int i = 6; i > 6 - n; i--) begin
      sdata_out = pat[i];
      #100 sclk_out = 1'b1;
      #100 sclk_out = 1'b0;
    end
    #100 sdata_out = ~sdata_out;
    #100;
  endtask
endmodule
`default_nettype wire

// ===== sim/tb_test_mode_tristate_entry.sv
// Self-checking bench for the test-mode three-state entry logic.
`timescale 1ns/1ps
`default_nettype none
module tb_test_mode_tristate_entry;
  logic mclk_in = 0, rst_in = 1, mode, sdata, sclk, exp, iso;
  logic [15:0] u_out = 0, u_oe = 0, u_pin = 0, p_out, p_oe, u_in;
  int error_cnt = 0, n_compared = 0, seed = 32'h7545;
  tester_model tm (.mode_out(mode), .sdata_out(sdata), .sclk_out(sclk));
  test_mode_tristate_entry dut_u (.mclk_in, .rst_in, .mode_pin_in(mode), .serial_test_data_in(sdata),
    .debug_shift_clock_in(sclk), .user_out_in(u_out), .user_oe_in(u_oe), .user_pin_in(u_pin),
    .pin_out(p_out), .pin_oe_out(p_oe), .user_in_out(u_in), .isolated_out(iso));
  initial forever #12.5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    #2;
    u_out <= 16'($random(seed));
    u_oe <= 16'($random(seed));
    u_pin <= 16'($random(seed));
  end
  task automatic check(input string nm, input logic [16:0] seen, input logic [16:0] want);
    n_compared++;
    if (seen !== want) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, want, seen);
    end
  endtask
  // Isolation is due only for the full command shifted while mode stands high.
  function automatic logic want_iso(input logic [6:0] pat, input int nbits, input logic mode_hi);
    return mode_hi && nbits == 7 && pat == 7'b0001011;
  endfunction
  task automatic stop_test();
    if (error_cnt == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    stop_test();
  end
  initial begin
    logic [6:0] p;
    repeat (8) @(posedge mclk_in);
    #2 rst_in = 0;
    for (int i = 0; i < 6; i++) begin
      p = i < 3 ? 7'h0b : i == 3 ? 7'h0a : i == 4 ? 7'h4b : 7'($random(seed));
      exp = want_iso(p, i == 2 ? 6 : 7, i != 1);
      tm.set_mode(i != 1);
      tm.shift(p, i == 2 ? 6 : 7);
      if (i == 3) tm.shift(7'h0b, 7);
      repeat (10) @(posedge mclk_in);
      #1 check("iso_oe", {iso, p_oe}, {exp, exp ? 16'h0 : u_oe});
      check("pin_out", {1'b0, p_out}, {1'b0, u_out});
      check("user_in", {1'b0, u_in}, {1'b0, u_pin});
      tm.set_mode(1'b0);
      @(posedge mclk_in);
      #1 check("exit_oe", {iso, p_oe}, {1'b0, u_oe});
    end
    stop_test();
  end
endmodule
bind test_mode_tristate_entry tristate_entry_assertions chk_u (.mclk_in, .rst_in, .mode_pin_in,
  .debug_shift_clock_in, .user_out_in, .user_oe_in, .user_pin_in, .pin_out, .pin_oe_out, .user_in_out, .isolated_out);
`default_nettype wire
